// ---- logic/iuf_filter.sv ----
`timescale 1ns/10ps
module iuf_filter #(
  parameter int unsigned BUF_DEPTH = iuf_pkg::BUF_DEPTH
) (
  input  wire logic                          mclk_i,
  input  wire logic                          reset_i,
  input  wire logic [7:0]                    in_data_i,
  input  wire logic                          in_valid_i,
  input  wire logic                          in_last_i,
  output logic                               in_ready_o,
  input  wire logic                          nh_match_en_i,
  input  wire iuf_pkg::iuf_nh_sel_type       nh_sel_i,
  input  wire logic [7:0]                    nh_number_i,
  input  wire logic                          flow_match_en_i,
  input  wire logic [iuf_pkg::FLOW_W-1:0]    flow_label_i,
  input  wire logic                          dscp_match_en_i,
  input  wire logic [iuf_pkg::DSCP_W-1:0]    dscp_i,
  input  wire iuf_pkg::iuf_port_sel_type     src_port_sel_i,
  input  wire logic [iuf_pkg::PORT_W-1:0]    src_port_min_i,
  input  wire logic [iuf_pkg::PORT_W-1:0]    src_port_max_i,
  input  wire iuf_pkg::iuf_port_sel_type     dst_port_sel_i,
  input  wire logic [iuf_pkg::PORT_W-1:0]    dst_port_min_i,
  input  wire logic [iuf_pkg::PORT_W-1:0]    dst_port_max_i,
  output logic                               verdict_valid_o,
  output logic                               verdict_pass_o,
  input  wire logic                          verdict_ready_i,
  output logic [iuf_pkg::CNT_W-1:0]          pass_count_o,
  output logic [iuf_pkg::CNT_W-1:0]          block_count_o
);
  import iuf_pkg::*;

  typedef enum logic [1:0] {
    IUF_RUN,
    IUF_EVAL,
    IUF_HOLD
  } iuf_state_type;

  // Inclusive range test shared by both port criteria.
  function automatic logic in_range(input logic [PORT_W-1:0] port,
                                    input logic [PORT_W-1:0] lo,
                                    input logic [PORT_W-1:0] hi);
    in_range = (port >= lo) && (port <= hi);
  endfunction : in_range

  iuf_state_type       state_reg;
  iuf_state_type       state_next;
  logic [IDX_W-1:0]    idx_reg;
  logic [15:0]         etype_reg;
  logic [3:0]          ver_reg;
  logic [DSCP_W-1:0]   dscp_reg;
  logic [FLOW_W-1:0]   flow_reg;
  logic [7:0]          nh_reg;
  logic [PORT_W-1:0]   src_reg;
  logic [PORT_W-1:0]   dst_reg;
  logic                nh_seen_reg;
  logic                udp_seen_reg;
  logic                pass_reg;
  logic [CNT_W-1:0]    pass_cnt_reg;
  logic [CNT_W-1:0]    block_cnt_reg;
  logic [7:0]          rd_byte;
  logic                rd_last;
  logic                rd_valid;
  logic                rd_ready;

  // Incoming bytes are buffered so the source sees back-pressure while a verdict waits.
  iuf_fifo #(
    .WIDTH (BUF_WIDTH),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .mclk_i     (mclk_i),
    .reset_i    (reset_i),
    .wr_data_i  ({in_last_i, in_data_i}),
    .wr_valid_i (in_valid_i),
    .wr_ready_o (in_ready_o),
    .rd_data_o  ({rd_last, rd_byte}),
    .rd_valid_o (rd_valid),
    .rd_ready_i (rd_ready)
  );

  // Draining stops outside the run state, which stalls the buffer and the source.
  assign rd_ready = (state_reg == IUF_RUN);
  wire take     = rd_valid && rd_ready;
  wire at_byte_nh = take && (idx_reg == OFS_IP_NXT_HDR);
  wire at_dst_lo  = take && (idx_reg == OFS_UDP_DST_LO);

  // Header classification of the frame just finished.
  wire is_ipv6 = (etype_reg == ETYPE_IPV6) && (ver_reg == IP_VERSION_6) && nh_seen_reg;
  wire is_udp  = is_ipv6 && (nh_reg == PROTO_UDP) && udp_seen_reg;

  // Next-header target: a fixed protocol number or the configured one.
  wire [7:0] nh_target = (nh_sel_i == IUF_NH_UDP)  ? PROTO_UDP    :
                         (nh_sel_i == IUF_NH_TCP)  ? PROTO_TCP    :
                         (nh_sel_i == IUF_NH_ICMP) ? PROTO_ICMPV6 :
                         nh_number_i;

  // Per-criterion acceptance; a disabled criterion accepts, except the source port, which blocks when set to ignore.
  wire nh_ok   = !nh_match_en_i || (is_ipv6 && (nh_reg == nh_target));
  wire flow_ok = !flow_match_en_i || (is_ipv6 && (flow_reg == flow_label_i));
  wire dscp_ok = !dscp_match_en_i || (is_ipv6 && (dscp_reg == dscp_i));
  wire src_ok  = (src_port_sel_i == IUF_PORT_RANGE) && is_udp &&
                 in_range(src_reg, src_port_min_i, src_port_max_i);
  wire dst_ok  = (dst_port_sel_i == IUF_PORT_IGNORE) || (is_udp &&
                 in_range(dst_reg, dst_port_min_i, dst_port_max_i));
  wire all_ok  = nh_ok && flow_ok && dscp_ok && src_ok && dst_ok;

  // Sequencing: run, evaluate one cycle after the last byte, hold until taken.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      IUF_RUN:  if (take && rd_last) state_next = IUF_EVAL;
      IUF_EVAL: state_next = IUF_HOLD;
      IUF_HOLD: if (verdict_ready_i) state_next = IUF_RUN;
      default:  state_next = IUF_RUN;
    endcase
  end

  assign verdict_valid_o = (state_reg == IUF_HOLD);
  assign verdict_pass_o  = pass_reg;
  assign pass_count_o    = pass_cnt_reg;
  assign block_count_o   = block_cnt_reg;

  // State, byte position and verdict register.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg <= IUF_RUN;
      idx_reg   <= RST_IDX;
      pass_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (take)
        idx_reg <= rd_last ? RST_IDX : ((idx_reg == IDX_MAX) ? IDX_MAX : idx_reg + 1'b1);
      if (state_reg == IUF_EVAL)
        pass_reg <= all_ok;
    end
  end

  // Header field capture by byte position.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      etype_reg <= RST_WORD;
      ver_reg   <= 4'h0;
      dscp_reg  <= RST_DSCP;
      flow_reg  <= RST_FLOW;
      nh_reg    <= RST_BYTE;
      src_reg   <= RST_WORD;
      dst_reg   <= RST_WORD;
    end
    else if (take)
    begin
      if (idx_reg == OFS_ETYPE_HI)   etype_reg[15:8]  <= rd_byte;
      if (idx_reg == OFS_ETYPE_LO)   etype_reg[7:0]   <= rd_byte;
      if (idx_reg == OFS_IP_VER_TC)  {ver_reg, dscp_reg[5:2]} <= rd_byte;
      if (idx_reg == OFS_IP_TC_FL)
        {dscp_reg[1:0], flow_reg[19:16]} <= {rd_byte[7:6], rd_byte[3:0]};
      if (idx_reg == OFS_IP_FL_MID)  flow_reg[15:8]   <= rd_byte;
      if (idx_reg == OFS_IP_FL_LO)   flow_reg[7:0]    <= rd_byte;
      if (idx_reg == OFS_IP_NXT_HDR) nh_reg           <= rd_byte;
      if (idx_reg == OFS_UDP_SRC_HI) src_reg[15:8]    <= rd_byte;
      if (idx_reg == OFS_UDP_SRC_LO) src_reg[7:0]     <= rd_byte;
      if (idx_reg == OFS_UDP_DST_HI) dst_reg[15:8]    <= rd_byte;
      if (idx_reg == OFS_UDP_DST_LO) dst_reg[7:0]     <= rd_byte;
    end
  end

  // Presence flags: a short frame never claims headers it did not carry.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      nh_seen_reg  <= 1'b0;
      udp_seen_reg <= 1'b0;
    end
    else if (take && idx_reg == RST_IDX)
    begin
      nh_seen_reg  <= 1'b0;
      udp_seen_reg <= 1'b0;
    end
    else
    begin
      if (at_byte_nh) nh_seen_reg  <= 1'b1;
      if (at_dst_lo)  udp_seen_reg <= 1'b1;
    end
  end

  // Pass and block totals, updated when the verdict is taken.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pass_cnt_reg  <= RST_CNT;
      block_cnt_reg <= RST_CNT;
    end
    else if (verdict_valid_o && verdict_ready_i)
    begin
      if (pass_reg) pass_cnt_reg  <= pass_cnt_reg + 1'b1;
      else          block_cnt_reg <= block_cnt_reg + 1'b1;
    end
  end

  // Checks on the verdict against the captured header fields.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  last_to_hold_a: assert property (take && rd_last |=> ##1 verdict_valid_o)
    else $error("verdict not presented two cycles after the last byte");
  hold_stable_a: assert property (
    verdict_valid_o && !verdict_ready_i |=> verdict_valid_o && $stable(verdict_pass_o))
    else $error("verdict changed while waiting");
  src_ignore_a: assert property (
    verdict_valid_o && src_port_sel_i == IUF_PORT_IGNORE |-> !verdict_pass_o)
    else $error("frame passed with source port selection ignored");
  src_range_a: assert property (
    (state_reg == IUF_EVAL) ##1 verdict_pass_o |->
    $past(src_reg) >= $past(src_port_min_i) && $past(src_reg) <= $past(src_port_max_i))
    else $error("passed frame source port outside range");
  dst_range_a: assert property (
    (state_reg == IUF_EVAL) && dst_port_sel_i == IUF_PORT_RANGE &&
    (dst_reg < dst_port_min_i || dst_reg > dst_port_max_i) |=> !verdict_pass_o)
    else $error("passed frame destination port outside range");
  flow_match_a: assert property (
    (state_reg == IUF_EVAL) && flow_match_en_i && flow_reg != flow_label_i
    |=> !verdict_pass_o)
    else $error("passed frame with wrong flow label");
  dscp_match_a: assert property (
    (state_reg == IUF_EVAL) && dscp_match_en_i && dscp_reg != dscp_i
    |=> !verdict_pass_o)
    else $error("passed frame with wrong code point");
  // The UDP option is checked on the criterion itself, so a wrong protocol code shows up
  // even when the port criteria would block the frame anyway.
  nh_udp_a: assert property (
    (state_reg == IUF_EVAL) && nh_match_en_i && nh_sel_i == IUF_NH_UDP
    |-> nh_ok == (is_ipv6 && nh_reg == PROTO_UDP))
    else $error("next header criterion disagrees with the UDP protocol number");
  nh_numeric_a: assert property (
    (state_reg == IUF_EVAL) && nh_match_en_i && nh_sel_i == IUF_NH_NUMERIC &&
    nh_reg != nh_number_i |=> !verdict_pass_o)
    else $error("passed frame with wrong next header number");
  non_ipv6_a: assert property ((state_reg == IUF_EVAL) && !is_udp |=> !verdict_pass_o)
    else $error("passed frame without a UDP header");

  pass_seen_c:  cover property (verdict_valid_o && verdict_pass_o && verdict_ready_i);
  block_seen_c: cover property (verdict_valid_o && !verdict_pass_o && verdict_ready_i);
  stall_c:      cover property (in_valid_i && !in_ready_o);
  wait_c:       cover property ((verdict_valid_o && !verdict_ready_i) [*3]);

endmodule : iuf_filter

// ---- shared/iuf_pkg.sv ----
package iuf_pkg;

  // Frame layout: untagged Ethernet header followed by a fixed IPv6 header and UDP.
  localparam int unsigned IDX_W          = 6;
  localparam logic [5:0]  OFS_ETYPE_HI   = 6'h0c;
  localparam logic [5:0]  OFS_ETYPE_LO   = 6'h0d;
  localparam logic [5:0]  OFS_IP_VER_TC  = 6'h0e;
  localparam logic [5:0]  OFS_IP_TC_FL   = 6'h0f;
  localparam logic [5:0]  OFS_IP_FL_MID  = 6'h10;
  localparam logic [5:0]  OFS_IP_FL_LO   = 6'h11;
  localparam logic [5:0]  OFS_IP_NXT_HDR = 6'h14;
  localparam logic [5:0]  OFS_UDP_SRC_HI = 6'h36;
  localparam logic [5:0]  OFS_UDP_SRC_LO = 6'h37;
  localparam logic [5:0]  OFS_UDP_DST_HI = 6'h38;
  localparam logic [5:0]  OFS_UDP_DST_LO = 6'h39;
  localparam logic [5:0]  IDX_MAX        = 6'h3f;

  // Field codes and widths.
  localparam logic [15:0] ETYPE_IPV6     = 16'h86dd;
  localparam logic [3:0]  IP_VERSION_6   = 4'h6;
  localparam logic [7:0]  PROTO_UDP      = 8'h11;
  localparam logic [7:0]  PROTO_TCP      = 8'h06;
  localparam logic [7:0]  PROTO_ICMPV6   = 8'h3a;
  localparam int unsigned FLOW_W         = 20;
  localparam int unsigned DSCP_W         = 6;
  localparam int unsigned PORT_W         = 16;
  localparam int unsigned CNT_W          = 16;

  // Stream buffer shape: byte plus end-of-frame marker, eight entries.
  localparam int unsigned BUF_WIDTH      = 9;
  localparam int unsigned BUF_DEPTH      = 8;

  // Reset values.
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [15:0] RST_WORD       = 16'h0000;
  localparam logic [19:0] RST_FLOW       = 20'h00000;
  localparam logic [5:0]  RST_DSCP       = 6'h00;
  localparam logic [5:0]  RST_IDX        = 6'h00;
  localparam logic [15:0] RST_CNT        = 16'h0000;

  typedef enum logic [1:0] {
    IUF_NH_NUMERIC,
    IUF_NH_UDP,
    IUF_NH_TCP,
    IUF_NH_ICMP
  } iuf_nh_sel_type;

  typedef enum logic {
    IUF_PORT_IGNORE,
    IUF_PORT_RANGE
  } iuf_port_sel_type;

endpackage : iuf_pkg

// ---- logic/iuf_fifo.sv ----
`timescale 1ns/10ps
module iuf_fifo #(
  parameter int unsigned WIDTH = iuf_pkg::BUF_WIDTH,
  parameter int unsigned DEPTH = iuf_pkg::BUF_DEPTH
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  output logic      [WIDTH-1:0] rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i
);
  import iuf_pkg::*;

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_B = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_B-1:0] CNT_FULL = CNT_B'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_B-1:0] count_reg;
  wire              push = wr_valid_i && wr_ready_o;
  wire              pop  = rd_valid_o && rd_ready_i;

  // Full and empty come straight from the occupancy count.
  assign wr_ready_o = (count_reg != CNT_FULL);
  assign rd_valid_o = (count_reg != '0);
  assign rd_data_o  = mem[rd_ptr_reg];

  // Storage is written only, never reset, so it maps onto plain memory.
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wr_ptr_reg] <= wr_data_i;
  end

  // Pointers wrap at the last entry so any depth works.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule : iuf_fifo

// ---- bench/iuf_frame_src.sv ----
`timescale 1ns/10ps
// Test port model: offers frame_mem byte by byte and holds each byte until it is taken or refused for 500 cycles, which raises hung_o.
module iuf_frame_src (
  input  wire logic       mclk_i,
  input  wire logic       ready_i,
  output logic      [7:0] data_o,
  output logic            valid_o,
  output logic            last_o,
  output logic            hung_o
);
  logic [7:0] frame_mem [0:63];

  // Released lines invert data_o on each gap cycle and once after a frame's last byte, so stale data is never mistaken.
  initial
  begin
    data_o  = 8'h00;
    valid_o = 1'b0;
    last_o  = 1'b0;
    hung_o  = 1'b0;
  end

  // Sends len bytes with gap idle cycles after each; a refused byte stays on the lines.
  task automatic send_frame(input int len, input int gap);
    int   i;
    int   w;
    logic rdy;
    for (i = 0; i < len; i++)
    begin
      @(negedge mclk_i);
      data_o  = frame_mem[i];
      valid_o = 1'b1;
      last_o  = (i == len - 1);
      rdy     = 1'b0;
      for (w = 0; w < 500 && !rdy; w++)
      begin
        if (w > 0)
          @(negedge mclk_i);
        rdy = (ready_i === 1'b1);
        @(posedge mclk_i);
      end
      if (!rdy)
        hung_o = 1'b1;
      repeat (gap)
      begin
        @(negedge mclk_i);
        valid_o = 1'b0;
        last_o  = 1'b0;
        data_o  = ~data_o;
      end
    end
    @(negedge mclk_i);
    valid_o = 1'b0;
    last_o  = 1'b0;
    data_o  = ~data_o;
  endtask : send_frame
endmodule : iuf_frame_src

// ---- bench/iuf_filter_tb_top.sv ----
`timescale 1ns/10ps
// Feeds built frames through the filter and checks every verdict and both counters.
module iuf_filter_tb_top;
  import iuf_pkg::*;
  logic             mclk_i;
  logic             reset_i;
  logic [7:0]       in_data;
  logic             in_valid;
  logic             in_last;
  logic             in_ready;
  logic             hung;
  logic             nh_en;
  iuf_nh_sel_type   nh_sel;
  logic [7:0]       nh_num;
  logic             flow_en;
  logic [19:0]      flow;
  logic             dscp_en;
  logic [5:0]       dscp;
  iuf_port_sel_type src_sel;
  iuf_port_sel_type dst_sel;
  logic [15:0]      smin, smax, dmin, dmax, f_etype, f_sport, f_dport, n_pass, n_block;
  logic             v_valid, v_pass, v_ready, hang;
  logic [19:0]      f_flow;
  logic [7:0]       f_nh;
  logic [5:0]       f_dscp;
  int               f_len, fails, samples_checked, exp_pass, exp_block, k;

  iuf_frame_src src_u (.mclk_i(mclk_i), .ready_i(in_ready), .data_o(in_data),
    .valid_o(in_valid), .last_o(in_last), .hung_o(hung));

  iuf_filter #(.BUF_DEPTH(BUF_DEPTH)) dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
    .in_data_i(in_data), .in_valid_i(in_valid), .in_last_i(in_last), .in_ready_o(in_ready),
    .nh_match_en_i(nh_en), .nh_sel_i(nh_sel), .nh_number_i(nh_num),
    .flow_match_en_i(flow_en), .flow_label_i(flow), .dscp_match_en_i(dscp_en),
    .dscp_i(dscp), .src_port_sel_i(src_sel), .src_port_min_i(smin), .src_port_max_i(smax),
    .dst_port_sel_i(dst_sel), .dst_port_min_i(dmin), .dst_port_max_i(dmax),
    .verdict_valid_o(v_valid), .verdict_pass_o(v_pass), .verdict_ready_i(v_ready),
    .pass_count_o(n_pass), .block_count_o(n_block));

  // Free-running 20 MHz clock.
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Baseline: only the port ranges are active and the frame sits inside both.
  task automatic defaults();
    nh_en   = 1'b0;
    nh_sel  = IUF_NH_NUMERIC;
    nh_num  = 8'h00;
    flow_en = 1'b0;
    flow    = 20'h5a5a5;
    dscp_en = 1'b0;
    dscp    = 6'h2e;
    src_sel = IUF_PORT_RANGE;
    dst_sel = IUF_PORT_RANGE;
    smin    = 16'h03e8;
    smax    = 16'h07d0;
    dmin    = 16'h0bb8;
    dmax    = 16'h0fa0;
    f_etype = ETYPE_IPV6;
    f_len   = 58;
    f_nh    = PROTO_UDP;
    f_flow  = 20'h5a5a5;
    f_dscp  = 6'h2e;
    f_sport = 16'h05dc;
    f_dport = 16'h0dac;
  endtask : defaults

  // Lays the header fields into the source model's frame memory.
  task automatic build();
    int i;
    for (i = 0; i < 64; i++)
      src_u.frame_mem[i] = i[7:0];
    src_u.frame_mem[OFS_ETYPE_HI]   = f_etype[15:8];
    src_u.frame_mem[OFS_ETYPE_LO]   = f_etype[7:0];
    src_u.frame_mem[OFS_IP_VER_TC]  = {IP_VERSION_6, f_dscp[5:2]};
    src_u.frame_mem[OFS_IP_TC_FL]   = {f_dscp[1:0], 2'b00, f_flow[19:16]};
    src_u.frame_mem[OFS_IP_FL_MID]  = f_flow[15:8];
    src_u.frame_mem[OFS_IP_FL_LO]   = f_flow[7:0];
    src_u.frame_mem[OFS_IP_NXT_HDR] = f_nh;
    src_u.frame_mem[OFS_UDP_SRC_HI] = f_sport[15:8];
    src_u.frame_mem[OFS_UDP_SRC_LO] = f_sport[7:0];
    src_u.frame_mem[OFS_UDP_DST_HI] = f_dport[15:8];
    src_u.frame_mem[OFS_UDP_DST_LO] = f_dport[7:0];
  endtask : build

  // Waits a bounded time for the verdict, checks it, takes it and checks the counters.
  task automatic take_verdict(input string what, input logic exp);
    int w;
    w = 0;
    do
    begin
      @(negedge mclk_i);
      w++;
    end
    while (v_valid !== 1'b1 && w < 400);
    if (w >= 400)
    begin
      fails++;
      hang = 1'b1;
      @(negedge mclk_i);
    end
    check(what, v_pass, exp);
    v_ready = 1'b1;
    @(negedge mclk_i);
    v_ready = 1'b0;
    if (exp)
      exp_pass++;
    else
      exp_block++;
    check("pass count", n_pass, exp_pass);
    check("block count", n_block, exp_block);
    $display("test %s done", what);
  endtask : take_verdict

  task automatic tx(input string what, input logic exp, input int gap);
    build();
    src_u.send_frame(f_len, gap);
    take_verdict(what, exp);
  endtask : tx

  // Cuts a hang short and goes to the closing report.
  initial
  begin
    fork
      wait (hang === 1'b1 || hung === 1'b1);
      repeat (60000) @(posedge mclk_i);
    join_any
    fails++;
    $display("ERROR run limit expected 0 seen 1");
    print_verdict();
  end

  // Main sequence of frames with their expected verdicts.
  initial
  begin
    fails = 0;
    samples_checked = 0;
    exp_pass = 0;
    exp_block = 0;
    hang = 1'b0;
    v_ready = 1'b0;
    reset_i = 1'b1;
    defaults();
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
    reset_i = 1'b0;
    check("ready after reset", in_ready, 1'b1);
    check("verdict after reset", v_valid, 1'b0);
    tx("plain", 1'b1, 0);
    f_sport = 16'h03e8; tx("src min", 1'b1, 2);
    f_sport = 16'h07d0; tx("src max", 1'b1, 0);
    f_sport = 16'h07d1; tx("src above", 1'b0, 0);
    f_sport = 16'h03e7; tx("src below", 1'b0, 0);
    f_sport = 16'h05dc; f_dport = 16'h0bb8; tx("dst min", 1'b1, 0);
    f_dport = 16'h0fa0; tx("dst max", 1'b1, 0);
    f_dport = 16'h0fa1; tx("dst above", 1'b0, 0);
    dst_sel = IUF_PORT_IGNORE; tx("dst ignore", 1'b1, 0);
    src_sel = IUF_PORT_IGNORE; tx("src ignore", 1'b0, 0);
    defaults();
    nh_en = 1'b1;
    nh_num = PROTO_UDP;
    for (k = 0; k < 4; k++)
    begin
      nh_sel = iuf_nh_sel_type'(k);
      tx("nh mode", (k < 2), 0);
    end
    nh_sel = IUF_NH_NUMERIC; nh_num = PROTO_TCP; tx("nh number", 1'b0, 0);
    nh_sel = IUF_NH_UDP; tx("nh number unused", 1'b1, 0);
    f_nh = PROTO_TCP; nh_sel = IUF_NH_TCP; tx("nh tcp frame", 1'b0, 0);
    nh_sel = IUF_NH_UDP; tx("nh udp on tcp", 1'b0, 0);
    defaults();
    flow_en = 1'b1; tx("flow equal", 1'b1, 0);
    flow = 20'hda5a5; tx("flow top bit", 1'b0, 0);
    defaults();
    dscp_en = 1'b1; tx("dscp equal", 1'b1, 0);
    dscp = 6'h2f; tx("dscp low bit", 1'b0, 0);
    dscp = 6'h0e; tx("dscp high bit", 1'b0, 0);
    defaults();
    f_etype = 16'h0800; tx("not ipv6", 1'b0, 0);
    f_etype = ETYPE_IPV6; f_len = 40; tx("no udp", 1'b0, 0);
    // A held verdict stops the drain, so the next frame must fill the buffer and wait.
    defaults();
    build();
    src_u.send_frame(f_len, 0);
    fork
      src_u.send_frame(f_len, 0);
    join_none
    repeat (40) @(negedge mclk_i);
    check("ready while held", in_ready, 1'b0);
    take_verdict("held", 1'b1);
    take_verdict("queued", 1'b1);
    print_verdict();
  end
endmodule : iuf_filter_tb_top
